// file: scwd_map.vh
`ifndef SCWD_MAP_VH
`define SCWD_MAP_VH

// APB register byte offsets
`define SCWD_OFF_CTRL 8'h00
`define SCWD_OFF_IRQ 8'h04
`define SCWD_OFF_STATUS 8'h08
`define SCWD_OFF_COUNT 8'h0c

// Control word field positions
`define SCWD_CW_DIR_BIT 7
`define SCWD_CW_TGT_BIT 6
`define SCWD_CW_MODE_BIT 5
`define SCWD_CW_ADDR_HI 5

// Register address that escapes to the indirect space
`define SCWD_IND_ADDR 6'h3f

// Operating mode encodings
`define SCWD_MODE_OFF 3'h0
`define SCWD_MODE_HIB 3'h1
`define SCWD_MODE_DOZE 3'h2
`define SCWD_MODE_IDLE 3'h3
`define SCWD_MODE_RX 3'h4
`define SCWD_MODE_TX 3'h5
`define SCWD_MODE_RST 3'h3

// Irq reset value and the bit count of the last bit in a byte
`define SCWD_IRQ_RST 8'h00
`define SCWD_BIT_LAST 3'h7

// Memory address widths
`define SCWD_DREG_AW 6
`define SCWD_IREG_AW 8
`define SCWD_PBUF_AW 7

`endif

// file: scwd_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for pins from outside the clock domain
module scwd_sync #(
  parameter W = 1,
  parameter [W-1:0] RSTV = {W{1'b0}}
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Asynchronous input and synchronised output
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] meta_r; // First stage, read only by the second

  // Two flops in series, both reset to the idle level
  always @(posedge sys_clk) begin
    if (reset) begin
      meta_r <= RSTV;
      dout <= RSTV;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule // scwd_sync

// file: scwd_mem.v
`timescale 1ns/100ps
// Byte-wide memory with one write port and a registered read port
module scwd_mem #(
  parameter AW = 6
) (
  // Clock
  input wire sys_clk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  // Read port, data one cycle after rd_en
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data
);

  reg [7:0] mem [0:(1<<AW)-1]; // Storage array

  // Write and read, read data from a register
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // scwd_mem

// file: scwd_top.v
`timescale 1ns/100ps
`include "scwd_map.vh"

// Functional notes
// - One control byte opens each transaction
// - Direct and burst data follow control byte
// - Indirect and byte mode take address byte
// - Control bit 7 one reads, zero writes
// - Control bit 6 picks buffer or registers
// - Low six bits give register address
// - Buffer bit 5 one byte, zero burst
// - Buffer accesses ignore low five bits
// - Six operating modes are provided
// - Hibernate keeps the serial port working
// - Reset or power-down disables the serial port
// - Sample on rising, change on falling
// - All bytes travel MSB first
// - Control byte time shifts out irq status
// - Bursts advance the address per byte
module scwd_top (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial port pins
  input wire spi_ssel_n,
  input wire spi_sclk,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe_n,
  // Operating mode outputs
  output reg [2:0] op_mode,
  output reg osc_en,
  output reg hibernate_state
);
  // Transaction phases
  localparam ST_CTRL = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_DONE = 2'd3;
  // Access targets
  localparam TG_DIR = 2'd0;
  localparam TG_IND = 2'd1;
  localparam TG_PB = 2'd2;
  // Synchronised pins
  wire ssel_n_s; // Select, active low
  wire sclk_s; // Serial clock level
  wire mosi_s; // Serial data in
  // Software registers
  reg [2:0] mode_r; // Operating mode
  reg [7:0] irq_r; // primary_irq_status
  reg [15:0] count_r; // Completed transactions
  // Serial engine state
  reg sclk_d_r; // Previous clock level
  reg sel_d_r; // Previous select state
  reg [2:0] bit_cnt_r; // Bits taken in this byte
  reg [7:0] rx_sh_r; // Receive shifter
  reg [7:0] tx_sh_r; // Transmit shifter
  reg [7:0] tx_hold_r; // Next byte to send
  reg [1:0] st_r; // Transaction phase
  reg [1:0] tgt_r; // Access target
  reg rd_r; // Read direction
  reg bmode_r; // Buffer single-byte mode
  reg [7:0] addr_r; // Current access address
  reg [7:0] last_cw_r; // Last control word
  reg rd_pend_r; // Memory read in flight
  reg got_byte_r; // Any byte seen this frame
  // Next-state terms
  reg [1:0] st_nxt;
  reg [1:0] tgt_nxt;
  reg rd_nxt;
  reg bmode_nxt;
  reg [7:0] addr_nxt;
  reg rd_go; // Fetch a byte for reading
  reg wr_go; // Store the received byte
  reg [31:0] rdata_nxt; // APB read mux
  // Memory read data
  wire [7:0] dreg_q;
  wire [7:0] ireg_q;
  wire [7:0] pbuf_q;
  // Port is alive only outside reset and power-down
  wire spi_en = (mode_r != `SCWD_MODE_OFF);
  wire sel_act = ~ssel_n_s & spi_en;
  wire sel_start = sel_act & ~sel_d_r;
  wire sel_end = ~sel_act & sel_d_r;
  wire sclk_rise = sel_act & sclk_s & ~sclk_d_r;
  wire sclk_fall = sel_act & ~sclk_s & sclk_d_r;
  wire byte_done = sclk_rise & (bit_cnt_r == `SCWD_BIT_LAST);
  wire [7:0] rx_byte = {rx_sh_r[6:0], mosi_s};
  // APB handshake terms
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire [7:0] st_word = {1'b0, bmode_r, tgt_r, rd_r, sel_act, st_r};
  // Pins are asynchronous, so sample them twice first
  scwd_sync #(.W(3), .RSTV(3'b100)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .din({spi_ssel_n, spi_sclk, spi_mosi}),
    .dout({ssel_n_s, sclk_s, mosi_s})
  );
  // Direct register set
  scwd_mem #(.AW(`SCWD_DREG_AW)) u_dreg (
    .sys_clk(sys_clk),
    .wr_en(wr_go & (tgt_r == TG_DIR)),
    .wr_addr(addr_r[`SCWD_DREG_AW-1:0]),
    .wr_data(rx_byte),
    .rd_en(rd_go & (tgt_nxt == TG_DIR)),
    .rd_addr(addr_nxt[`SCWD_DREG_AW-1:0]),
    .rd_data(dreg_q)
  );
  // Indirect register set
  scwd_mem #(.AW(`SCWD_IREG_AW)) u_ireg (
    .sys_clk(sys_clk),
    .wr_en(wr_go & (tgt_r == TG_IND)),
    .wr_addr(addr_r),
    .wr_data(rx_byte),
    .rd_en(rd_go & (tgt_nxt == TG_IND)),
    .rd_addr(addr_nxt),
    .rd_data(ireg_q)
  );
  // Packet buffer
  scwd_mem #(.AW(`SCWD_PBUF_AW)) u_pbuf (
    .sys_clk(sys_clk),
    .wr_en(wr_go & (tgt_r == TG_PB)),
    .wr_addr(addr_r[`SCWD_PBUF_AW-1:0]),
    .wr_data(rx_byte),
    .rd_en(rd_go & (tgt_nxt == TG_PB)),
    .rd_addr(addr_nxt[`SCWD_PBUF_AW-1:0]),
    .rd_data(pbuf_q)
  );
  // Decode of each completed byte
  always @* begin
    st_nxt = st_r;
    tgt_nxt = tgt_r;
    rd_nxt = rd_r;
    bmode_nxt = bmode_r;
    addr_nxt = addr_r;
    rd_go = 1'b0;
    wr_go = 1'b0;
    if (byte_done) begin
      case (st_r)
        // First byte is always the control word
        ST_CTRL: begin
          rd_nxt = rx_byte[`SCWD_CW_DIR_BIT];
          if (rx_byte[`SCWD_CW_TGT_BIT]) begin
            // Buffer: only the mode bit matters
            tgt_nxt = TG_PB;
            bmode_nxt = rx_byte[`SCWD_CW_MODE_BIT];
            addr_nxt = 8'h00;
            if (rx_byte[`SCWD_CW_MODE_BIT]) begin
              st_nxt = ST_ADDR;
            end else begin
              st_nxt = ST_DATA;
              rd_go = rx_byte[`SCWD_CW_DIR_BIT];
            end
          end else begin
            // Registers: low six bits are the address
            bmode_nxt = 1'b0;
            addr_nxt = {2'b00, rx_byte[`SCWD_CW_ADDR_HI:0]};
            if (rx_byte[`SCWD_CW_ADDR_HI:0] == `SCWD_IND_ADDR) begin
              tgt_nxt = TG_IND;
              st_nxt = ST_ADDR;
            end else begin
              tgt_nxt = TG_DIR;
              st_nxt = ST_DATA;
              rd_go = rx_byte[`SCWD_CW_DIR_BIT];
            end
          end
        end
        // Extra address byte, then data
        ST_ADDR: begin
          addr_nxt = rx_byte;
          st_nxt = ST_DATA;
          rd_go = rd_r;
        end
        // Data byte, burst steps the address
        ST_DATA: begin
          wr_go = ~rd_r;
          if (bmode_r) begin
            st_nxt = ST_DONE;
          end else begin
            addr_nxt = addr_r + 8'h01;
            rd_go = rd_r;
          end
        end
        // Bytes after a single-byte access are dropped
        default: begin
          st_nxt = ST_DONE;
        end
      endcase
    end
  end

  // Serial engine, restarted by each select edge
  always @(posedge sys_clk) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      tx_hold_r <= 8'h00;
      st_r <= ST_CTRL;
      tgt_r <= TG_DIR;
      rd_r <= 1'b0;
      bmode_r <= 1'b0;
      addr_r <= 8'h00;
      last_cw_r <= 8'h00;
      rd_pend_r <= 1'b0;
      got_byte_r <= 1'b0;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      // Output pin flops, released when not selected
      spi_miso <= sel_act & tx_sh_r[7];
      spi_miso_oe_n <= ~sel_act;
      sel_d_r <= sel_act;
      rd_pend_r <= rd_go;
      if (~sel_act) begin
        // Idle: next frame starts at the control word
        bit_cnt_r <= 3'h0;
        st_r <= ST_CTRL;
        got_byte_r <= 1'b0;
        if (sel_end) begin
          tx_sh_r <= 8'h00;
        end
      end else if (sel_start) begin
        // Status leads the control word out
        tx_sh_r <= irq_r;
        bit_cnt_r <= 3'h0;
        st_r <= ST_CTRL;
      end else begin
        if (sclk_rise) begin
          rx_sh_r <= rx_byte;
          bit_cnt_r <= bit_cnt_r + 3'h1;
        end
        if (sclk_fall) begin
          // New byte on the first fall after eight bits
          if (bit_cnt_r == 3'h0) begin
            tx_sh_r <= tx_hold_r;
          end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          end
        end
        if (byte_done) begin
          got_byte_r <= 1'b1;
          tx_hold_r <= 8'h00;
          if (st_r == ST_CTRL) begin
            last_cw_r <= rx_byte;
          end
        end
        if (rd_pend_r) begin
          // Fetched byte waits for the next fall
          case (tgt_r)
            TG_DIR: tx_hold_r <= dreg_q;
            TG_IND: tx_hold_r <= ireg_q;
            default: tx_hold_r <= pbuf_q;
          endcase
        end
        st_r <= st_nxt;
        tgt_r <= tgt_nxt;
        rd_r <= rd_nxt;
        bmode_r <= bmode_nxt;
        addr_r <= addr_nxt;
      end
    end
  end

  // APB read data mux
  always @* begin
    rdata_nxt = 32'h00000000;
    case (paddr)
      `SCWD_OFF_CTRL: rdata_nxt = {29'h0, mode_r};
      `SCWD_OFF_IRQ: rdata_nxt = {24'h0, irq_r};
      `SCWD_OFF_STATUS: rdata_nxt = {16'h0, last_cw_r, st_word};
      `SCWD_OFF_COUNT: rdata_nxt = {16'h0, count_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // APB slave: one wait-free access phase per transfer
  always @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0; // Error stands with pready only
      if (apb_setup) begin
        prdata <= rdata_nxt;
        pslverr <= (paddr != `SCWD_OFF_CTRL) && (paddr != `SCWD_OFF_IRQ) &&
          (paddr != `SCWD_OFF_STATUS) && (paddr != `SCWD_OFF_COUNT);
      end
    end
  end

  // Software registers, transaction counter and mode outputs
  always @(posedge sys_clk) begin
    if (reset) begin
      mode_r <= `SCWD_MODE_RST;
      irq_r <= `SCWD_IRQ_RST;
      count_r <= 16'h0000;
      op_mode <= `SCWD_MODE_OFF;
      osc_en <= 1'b0;
      hibernate_state <= 1'b0;
    end else begin
      if (apb_done & pwrite) begin
        // Only the six defined modes are accepted
        if ((paddr == `SCWD_OFF_CTRL) && (pwdata[2:0] <= `SCWD_MODE_TX)) begin
          mode_r <= pwdata[2:0];
        end
        if (paddr == `SCWD_OFF_IRQ) begin
          irq_r <= pwdata[7:0];
        end
      end
      // Count frames that carried at least one byte
      if (sel_end & got_byte_r) begin
        count_r <= count_r + 16'h0001;
      end
      // Mode outputs: oscillator off in power-down and hibernate
      op_mode <= mode_r;
      osc_en <= (mode_r != `SCWD_MODE_OFF) && (mode_r != `SCWD_MODE_HIB);
      hibernate_state <= (mode_r == `SCWD_MODE_HIB);
    end
  end

endmodule // scwd_top

// file: scwd_monitor.sv
`timescale 1ns/100ps
// Port checks for the serial front end
module scwd_monitor (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Serial and mode
  input wire spi_ssel_n,
  input wire spi_miso,
  input wire spi_miso_oe_n,
  input wire [2:0] op_mode,
  input wire osc_en,
  input wire hibernate_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_alone: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  a_err_in_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_err_zero: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0) else $error("refused read not zero");
  a_miso_released: assert property (spi_ssel_n [*6] |->
    spi_miso_oe_n && !spi_miso) else $error("miso driven while idle");
  a_mode_legal: assert property (op_mode <= 3'h5)
    else $error("illegal mode");
  a_hib_flag: assert property ($stable(op_mode) |->
    hibernate_state == (op_mode == 3'h1)) else $error("hibernate flag");
  a_osc_follows: assert property ($stable(op_mode) |->
    osc_en == (op_mode >= 3'h2)) else $error("osc enable");
  a_reset_quiet: assert property (disable iff (1'h0) reset |=>
    !pready && spi_miso_oe_n && !osc_en && op_mode == 3'h0)
    else $error("outputs active in reset");
  // Main scenarios
  c_frame: cover property ($fell(spi_ssel_n));
  c_hib: cover property (hibernate_state && !spi_ssel_n);
  c_refused: cover property (pready && pslverr);
endmodule // scwd_monitor

bind scwd_top scwd_monitor u_scwd_monitor (.sys_clk, .reset, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .spi_ssel_n, .spi_miso,
  .spi_miso_oe_n, .op_mode, .osc_en, .hibernate_state);

// file: scwd_host.sv
`timescale 1ns/100ps
// Serial master model, mode 0, half period four clocks
module scwd_host (
  // Clock
  input wire sys_clk,
  // Serial pins
  output logic spi_ssel_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire spi_miso
);
  logic [7:0] tx_q[$]; // Bytes to send
  logic [7:0] rx_q[$]; // Bytes captured
  // Idle pins
  initial begin
    spi_ssel_n = 1'h1;
    spi_sclk = 1'h0;
    spi_mosi = 1'h0;
  end
  // Wait clock edges
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One framed transaction, control byte first
  task run;
    logic [7:0] r;
    rx_q = {};
    @(posedge sys_clk);
    spi_ssel_n <= 1'h0;
    wt(2);
    foreach (tx_q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        spi_mosi <= tx_q[i][k];
        wt(4);
        spi_sclk <= 1'h1;
        wt(1);
        r = {r[6:0], spi_miso};
        wt(3);
        spi_sclk <= 1'h0;
      end
      rx_q.push_back(r);
    end
    wt(4);
    spi_ssel_n <= 1'h1;
    spi_mosi <= ~spi_mosi;
    wt(8);
  endtask
endmodule // scwd_host

// file: test_spi_control_word_decoder.sv
`timescale 1ns/100ps
// Bench with reference memories for the serial front end
module test_spi_control_word_decoder;
  // Bus side
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, irq, last_cw, a;
  logic [31:0] pwdata, prdata, rd;
  // Serial and mode
  logic spi_ssel_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe_n;
  logic [2:0] op_mode;
  logic osc_en, hibernate_state;
  // Tallies and reference state
  int err_count, comparisons, cyc, frames, off;
  int seed = 38613;
  int mem[3][256];
  int exp_q[$];
  scwd_top u_scwd_top (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .spi_ssel_n, .spi_sclk, .spi_mosi,
    .spi_miso, .spi_miso_oe_n, .op_mode, .osc_en, .hibernate_state);
  // Released line reads as the inverse, so a missing drive is caught
  wire miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;
  scwd_host u_scwd_host (.sys_clk, .spi_ssel_n, .spi_sclk, .spi_mosi,
    .spi_miso(miso_line));
  // Clock
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Compare and tally
  task chk(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer held until pready
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Read a register and compare
  task rchk(string n, logic [7:0] ad, logic [31:0] e);
    apb(1'h0, ad, 32'h0);
    chk(n, rd, e);
  endtask
  // One frame; the model keeps memory and expected bytes
  task xfer(input logic [7:0] cw, input int ab, input int n);
    int sp, p, sz;
    logic [7:0] d;
    logic bm;
    bm = cw[6] & cw[5];
    sp = cw[6] ? 2 : int'(cw[5:0] == 6'h3f);
    sz = sp == 0 ? 64 : (sp == 1 ? 256 : 128);
    p = ab >= 0 ? ab : (cw[6] ? 0 : cw[5:0]);
    u_scwd_host.tx_q = {cw};
    exp_q = {irq};
    if (ab >= 0) begin
      u_scwd_host.tx_q.push_back(ab[7:0]);
      exp_q.push_back(-1);
    end
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      u_scwd_host.tx_q.push_back(d);
      if (cw[7])
        exp_q.push_back(bm && i > 0 ? 0 : mem[sp][p]);
      else begin
        exp_q.push_back(-1);
        if (!(bm && i > 0) && !off)
          mem[sp][p] = d;
      end
      p = (p + 1) % sz;
    end
    u_scwd_host.run();
    if (!off) begin
      frames++;
      last_cw = cw;
      chk("irq out", u_scwd_host.rx_q[0], irq);
      for (int k = 1; k < exp_q.size(); k++)
        if (exp_q[k] >= 0)
          chk("data", u_scwd_host.rx_q[k], exp_q[k]);
    end
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_sim;
    end
  end
  // Main sequence
  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    irq = 8'h0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rchk("ctrl", 8'h00, 3);
    rchk("irq", 8'h04, 0);
    rchk("count", 8'h0c, 0);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", err, 1);
    chk("bad read", rd, 0);
    $display("test reset done");
    irq = $random(seed);
    apb(1'h1, 8'h04, {24'h0, irq});
    for (int m = 0; m < 7; m++) begin
      apb(1'h1, 8'h00, m);
      repeat (3) @(posedge sys_clk);
      chk("mode", op_mode, m < 6 ? m : 5);
      chk("osc", osc_en, m > 1);
      chk("hib", hibernate_state, m == 1);
    end
    apb(1'h1, 8'h00, 3);
    $display("test modes done");
    a = $random(seed) & 8'h2f;
    xfer({2'h0, a[5:0]}, -1, 4);
    xfer({2'h2, a[5:0]}, -1, 4);
    a = $random(seed);
    xfer(8'h3f, a, 3);
    xfer(8'hbf, a, 3);
    xfer({3'h2, a[4:0]}, -1, 5);
    xfer({3'h6, a[7:3]}, -1, 5);
    xfer({3'h3, a[4:0]}, a & 8'h7f, 2);
    xfer({3'h7, a[6:2]}, a & 8'h7f, 2);
    apb(1'h0, 8'h08, 32'h0);
    chk("status", rd[15:8], last_cw);
    rchk("count", 8'h0c, frames);
    $display("test frames done");
    apb(1'h1, 8'h00, 1);
    a = $random(seed) & 8'h2f;
    xfer({2'h0, a[5:0]}, -1, 2);
    xfer({2'h2, a[5:0]}, -1, 2);
    apb(1'h1, 8'h00, 0);
    off = 1;
    xfer({2'h0, a[5:0]}, -1, 2);
    off = 0;
    apb(1'h1, 8'h00, 3);
    repeat (4) @(posedge sys_clk);
    xfer({2'h2, a[5:0]}, -1, 2);
    rchk("count", 8'h0c, frames);
    $display("test power modes done");
    // Reset in mid-run returns the registers to their reset values
    reset <= 1'h1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'h0;
    rchk("ctrl", 8'h00, 3);
    rchk("irq", 8'h04, 0);
    rchk("count", 8'h0c, 0);
    $display("test reset in run done");
    end_sim;
  end
endmodule // test_spi_control_word_decoder
